// File: port_irq_data_ctrl.sv
`timescale 1ns/10ps
module port_irq_data_ctrl import port_ctrl_pkg::*; (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_awvalid,
    input  wire logic [31:0] i_awaddr,
    output logic             o_awready,
    input  wire logic        i_wvalid,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    output logic             o_wready,
    output logic             o_bvalid,
    output logic [1:0]       o_bresp,
    input  wire logic        i_bready,
    input  wire logic        i_arvalid,
    input  wire logic [31:0] i_araddr,
    output logic             o_arready,
    output logic             o_rvalid,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    input  wire logic        i_rready,
    input  wire logic        i_dma_access,
    input  wire logic        i_forward_strobe_in,
    input  wire logic        i_reverse_strobe_in,
    input  wire logic        i_active_select_in,
    input  wire logic        i_host_init_in,
    input  wire logic [31:0] i_latch_rdata,
    output logic             o_latch_write_strobe,
    output logic             o_latch_output_enable,
    output logic [31:0]      o_latch_wdata,
    output logic             o_latch_full_word,
    output logic             o_latch_dma_access,
    output logic             o_port_control_irq,
    output logic             o_port_data_irq,
    output logic [1:0]       o_dma_req,
    output logic             o_port_busy_out,
    output logic             o_port_ack_out,
    output logic             o_port_owns_pins
);
    ctrl_t       ctrl_ff;
    logic [31:0] cond_ff, mask_ff, nxt_cond, irq_flags, cond_set, cond_clr;
    logic [31:0] awaddr_ff, wdata_ff, raddr_ff, wd, ctrl_wr;
    logic [3:0]  sync1_ff, sync2_ff, prev_ff, rise, fall, wstrb_ff;
    logic [3:0]  ack_cnt_ff;
    logic [2:0]  prev_mode_ff;
    logic [1:0]  rd_stage_ff, bc_ff;
    logic        aw_got_ff, w_got_ff, aw_dma_ff, wr_do, rd_take;
    logic        data_access, mode_on, fwd_mode, rev_mode, word_mode;
    logic        trigger, hs_drq_set, hs_cmd_set, entering_compat;
    hs_state_t   hs_ff;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] bm;
        bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~bm) | (data & bm);
    endfunction

    assign mode_on   = ctrl_ff.port_protocol_select != MODE_OFF;
    assign fwd_mode  = ctrl_ff.port_protocol_select == MODE_COMPAT ||
                       ctrl_ff.port_protocol_select == MODE_ECPFWD;
    assign rev_mode  = ctrl_ff.port_protocol_select == MODE_BYTE ||
                       ctrl_ff.port_protocol_select == MODE_ECPREV;
    // Full-word transfers only make sense in the forward byte streams
    assign word_mode = ctrl_ff.full_word_enable && fwd_mode; // R5
    assign wr_do     = aw_got_ff && w_got_ff && !o_bvalid;
    assign wd        = merge(ZERO_WORD, wdata_ff, wstrb_ff);
    assign ctrl_wr   = merge({19'h0_0000, ctrl_ff}, wdata_ff, wstrb_ff);
    assign rd_take   = o_arready && i_arvalid;
    // Decode ignores the mode so the latch stays reachable when disabled
    assign data_access = (wr_do && awaddr_ff == ADDR_DATA) ||
                         (rd_take && i_araddr == ADDR_DATA); // R3

    // Host lines: two stages before any edge logic sees them
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            prev_ff  <= 4'h0;
        end else begin
            sync1_ff <= {i_host_init_in, i_active_select_in,
                         i_reverse_strobe_in, i_forward_strobe_in}; // R25
            sync2_ff <= sync1_ff; // R25
            prev_ff  <= sync2_ff;
        end
    end
    assign rise = sync2_ff & ~prev_ff;
    assign fall = ~sync2_ff & prev_ff;

    // AXI write channel; address and data accepted in either order
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= ZERO_WORD;
            wdata_ff  <= ZERO_WORD;
            wstrb_ff  <= 4'h0;
            aw_dma_ff <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
        end else begin
            if (o_awready && i_awvalid) begin
                o_awready <= 1'b0;
                aw_got_ff <= 1'b1;
                awaddr_ff <= i_awaddr;
                aw_dma_ff <= i_dma_access;
            end
            if (o_wready && i_wvalid) begin
                o_wready <= 1'b0;
                w_got_ff <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (wr_do) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= (awaddr_ff == ADDR_CTRL ||
                              awaddr_ff == ADDR_COND ||
                              awaddr_ff == ADDR_MASK ||
                              awaddr_ff == ADDR_FLAGS ||
                              awaddr_ff == ADDR_DATA) ? RESP_OKAY
                                                      : RESP_SLVERR;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // AXI read: take, then one cycle for the external latch, then answer
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_arready   <= 1'b1;
            o_rvalid    <= 1'b0;
            o_rdata     <= ZERO_WORD;
            o_rresp     <= RESP_OKAY;
            raddr_ff    <= ZERO_WORD;
            rd_stage_ff <= RD_IDLE;
        end else begin
            if (rd_take) begin
                o_arready   <= 1'b0;
                raddr_ff    <= i_araddr;
                rd_stage_ff <= RD_FETCH;
            end else if (rd_stage_ff == RD_FETCH) begin
                rd_stage_ff <= RD_RESP;
                o_rvalid    <= 1'b1;
                o_rresp     <= RESP_OKAY;
                case (raddr_ff)
                    ADDR_CTRL:  o_rdata <= {19'h0_0000, ctrl_ff};
                    ADDR_COND:  o_rdata <= cond_ff;
                    ADDR_MASK:  o_rdata <= mask_ff;
                    ADDR_FLAGS: o_rdata <= irq_flags;
                    ADDR_DATA:  o_rdata <= word_mode ? i_latch_rdata
                                    : (i_latch_rdata & BYTE_BITS); // R5
                    default: begin
                        o_rdata <= ZERO_WORD;
                        o_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid    <= 1'b0;
                o_arready   <= 1'b1;
                rd_stage_ff <= RD_IDLE;
            end
        end
    end

    // External latch strobes, one cycle each
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_latch_write_strobe  <= 1'b0;
            o_latch_output_enable <= 1'b0;
            o_latch_wdata         <= ZERO_WORD;
            o_latch_full_word     <= 1'b0;
            o_latch_dma_access    <= 1'b0;
        end else begin
            o_latch_write_strobe  <= wr_do && awaddr_ff == ADDR_DATA; // R2
            o_latch_output_enable <= rd_take && i_araddr == ADDR_DATA; // R2
            o_latch_full_word     <= word_mode; // R5
            if (wr_do && awaddr_ff == ADDR_DATA) begin
                o_latch_wdata      <= word_mode ? wd : (wd & BYTE_BITS);
                o_latch_dma_access <= aw_dma_ff; // R20
            end else if (rd_take && i_araddr == ADDR_DATA) begin
                o_latch_dma_access <= i_dma_access; // R20
            end
        end
    end

    // Control and mask; writable at any time, enabled or not
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_ff      <= ctrl_t'(CTRL_RESET); // R6 R7
            mask_ff      <= ZERO_WORD; // R8
            prev_mode_ff <= MODE_OFF;
        end else begin
            prev_mode_ff <= ctrl_ff.port_protocol_select;
            if (wr_do && awaddr_ff == ADDR_CTRL) begin
                ctrl_ff <= ctrl_t'(ctrl_wr[12:0]); // R10
            end
            if (wr_do && awaddr_ff == ADDR_MASK) begin
                mask_ff <= merge(mask_ff, wdata_ff, wstrb_ff) & COND_BITS;
            end
        end
    end

    assign entering_compat = ctrl_ff.port_protocol_select == MODE_COMPAT &&
                             prev_mode_ff != MODE_COMPAT;

    always_comb begin
        cond_set = ZERO_WORD;
        for (int i = 0; i < 4; i++) begin
            cond_set[2*i]   = rise[i] && mode_on; // R11
            cond_set[2*i+1] = fall[i] && mode_on; // R11
        end
        cond_set[BIT_REINIT] = rise[3] && mode_on &&
            ctrl_ff.port_protocol_select != MODE_COMPAT; // R12
        cond_set[BIT_CMD]    = hs_cmd_set; // R12
        cond_set[BIT_DREQ]   = hs_drq_set; // R13
        cond_clr = ZERO_WORD;
        if (wr_do && awaddr_ff == ADDR_COND) begin
            cond_clr = wd & COND_BITS; // R14
        end else if (wr_do && awaddr_ff == ADDR_FLAGS) begin
            cond_clr = wd & FLAG_BITS; // R1 R24
        end
        if (entering_compat) begin
            cond_clr[BIT_REINIT] = 1'b1; // R17
        end
        if (data_access &&
            ctrl_ff.port_protocol_select != MODE_NIBBLE) begin
            cond_clr[BIT_DREQ] = 1'b1; // R4
        end
        // A new event in the clearing cycle survives the clear
        nxt_cond = ((cond_ff & ~cond_clr) | cond_set) & COND_BITS;
    end

    assign irq_flags = mode_on ? (cond_ff & mask_ff & FLAG_BITS)
                               : ZERO_WORD; // R16

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cond_ff            <= ZERO_WORD; // R8
            o_port_control_irq <= 1'b0;
            o_port_data_irq    <= 1'b0;
            o_dma_req          <= 2'h0;
            o_port_owns_pins   <= 1'b0; // R6
        end else begin
            cond_ff            <= nxt_cond;
            o_port_control_irq <= |irq_flags; // R1 R15 R23
            o_port_data_irq    <= cond_ff[BIT_DREQ] && mode_on &&
                                  !ctrl_ff.dma_select_bit &&
                                  mask_ff[BIT_DREQ]; // R15 R21
            o_dma_req          <= 2'h0;
            if (cond_ff[BIT_DREQ] && mode_on && ctrl_ff.dma_select_bit &&
                ctrl_ff.port_protocol_select != MODE_NIBBLE) begin
                o_dma_req[ctrl_ff.dma_channel_select] <= 1'b1; // R22
            end
            o_port_owns_pins   <= mode_on; // R6
        end
    end

    // Handshake: forward modes wait on the host strobe, reverse modes on
    // the host request; nibble mode never requests on its own
    assign trigger = (fwd_mode && rise[0]) || (rev_mode && rise[1]); // R19
    assign hs_cmd_set = hs_ff == HS_IDLE && trigger &&
        ctrl_ff.port_protocol_select == MODE_ECPFWD &&
        sync2_ff[1] == ctrl_ff.cmd_polarity; // R12
    assign hs_drq_set = hs_ff == HS_IDLE && trigger && !hs_cmd_set &&
        !(word_mode && bc_ff != BC_LAST); // R13

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hs_ff      <= HS_IDLE;
            bc_ff      <= 2'h0;
            ack_cnt_ff <= 4'h0;
        end else if (!mode_on || !word_mode && bc_ff != 2'h0) begin
            hs_ff <= mode_on ? hs_ff : HS_IDLE;
            bc_ff <= 2'h0;
        end else begin
            case (hs_ff)
                HS_IDLE: begin
                    if (hs_cmd_set) begin
                        hs_ff <= HS_CMD;
                    end else if (hs_drq_set) begin
                        hs_ff <= HS_REQ;
                        bc_ff <= 2'h0;
                    end else if (trigger) begin
                        // Intermediate bytes of a word are acked at once
                        hs_ff      <= HS_ACK;
                        bc_ff      <= bc_ff + 2'h1;
                        ack_cnt_ff <= ctrl_ff.acknowledge_pulse_length;
                    end
                end
                HS_REQ: begin
                    if (data_access) begin
                        hs_ff      <= HS_ACK; // R4 R18
                        ack_cnt_ff <= ctrl_ff.acknowledge_pulse_length;
                    end
                end
                HS_CMD: begin
                    if (!cond_ff[BIT_CMD]) begin
                        hs_ff      <= HS_ACK; // R24
                        ack_cnt_ff <= ctrl_ff.acknowledge_pulse_length;
                    end
                end
                HS_ACK: begin
                    if (ack_cnt_ff == 4'h0) begin
                        hs_ff <= HS_IDLE;
                    end else begin
                        ack_cnt_ff <= ack_cnt_ff - 4'h1;
                    end
                end
                default: hs_ff <= HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_port_busy_out <= 1'b0; // R7
            o_port_ack_out  <= 1'b0;
        end else begin
            o_port_busy_out <= ctrl_ff.busy_override_bit ?
                               !ctrl_ff.soft_busy_bit : hs_ff == HS_IDLE;
            o_port_ack_out  <= hs_ff == HS_ACK;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_fwd_rise;
        !i_forward_strobe_in ##1 i_forward_strobe_in [*3];
    endsequence
    sequence s_data_read;
        rd_take && i_araddr == ADDR_DATA;
    endsequence

    a_ctrl_irq_or: // R23
        assert property (o_port_control_irq == $past(|irq_flags))
        else $error("control irq not OR of flags");
    a_mask_gates_irq: // R16
        assert property ((mask_ff == ZERO_WORD) [*2] |-> !o_port_control_irq)
        else $error("control irq with all masks clear");
    a_w1c_condition: // R14
        assert property (wr_do && awaddr_ff == ADDR_COND && wd[0] &&
                         !cond_set[0] |=> !cond_ff[0])
        else $error("condition not cleared by write of one");
    a_flag_clear: // R1
        assert property (wr_do && awaddr_ff == ADDR_FLAGS && wd[1] &&
                         !cond_set[1] |=> !irq_flags[1] && !cond_ff[1])
        else $error("flag write did not clear flag and condition");
    a_write_strobe: // R2
        assert property (wr_do && awaddr_ff == ADDR_DATA |=>
                         o_latch_write_strobe ##1 !o_latch_write_strobe)
        else $error("latch write strobe not a single pulse");
    a_read_enable: // R2
        assert property (s_data_read |=> o_latch_output_enable ##1
                         (o_rvalid && !o_latch_output_enable))
        else $error("latch read sequence wrong");
    a_access_clears_req: // R4
        assert property (data_access && !hs_drq_set &&
            ctrl_ff.port_protocol_select != MODE_NIBBLE |=>
            !cond_ff[BIT_DREQ])
        else $error("data access left request pending");
    a_data_irq_path: // R21
        assert property (cond_ff[BIT_DREQ] && mode_on && mask_ff[BIT_DREQ]
                         && !ctrl_ff.dma_select_bit |=> o_port_data_irq)
        else $error("data irq missing");
    a_dma_not_irq: // R22
        assert property (cond_ff[BIT_DREQ] && mode_on &&
            ctrl_ff.dma_select_bit &&
            ctrl_ff.port_protocol_select != MODE_NIBBLE |=>
            !o_port_data_irq && o_dma_req != 2'h0)
        else $error("dma mode still raised data irq");
    a_edge_synced: // R25
        assert property ((s_fwd_rise and (mode_on && !wr_do) [*4]) |=>
                         cond_ff[0])
        else $error("forward strobe rise not captured");
    a_reinit_autoclr: // R17
        assert property (entering_compat && !cond_set[BIT_REINIT] |=>
                         !cond_ff[BIT_REINIT])
        else $error("reinit condition kept in compatibility mode");
    a_cmd_release: // R24
        assert property (hs_ff == HS_CMD && !cond_ff[BIT_CMD] && mode_on
                         && (word_mode || bc_ff == 2'h0) |=> hs_ff == HS_ACK)
        else $error("command hold not released");
endmodule

// File: port_ctrl_pkg.sv
// Overview of operation
// R1: Each set edge flag raises control interrupt
// R2: Data address access pulses latch strobe/enable
// R3: Latch strobe decode works while port disabled
// R4: Data access clears request, advances handshake
// R5: Access 8 bits, 32 with full-word enable; code gives 32 only in compat and ECP forward modes
// R6: Reset clears mode, returns pins to GPIO
// R7: Reset busy bits to one, ack length ones
// R8: Reset clears all conditions and masks
// R9: Software sets GPIO enables before enabling port
// R10: Registers writable while port is enabled
// R11: Rise and fall conditions for four inputs
// R12: Command and host reinit conditions are set
// R13: Data request set when byte moves
// R14: Writing one clears condition, zero keeps
// R15: Separate control and data interrupt outputs
// R16: Flag true only when condition and mask
// R17: Reinit condition clears entering compatibility mode
// R18: Serviced request moves data through latch
// R19: Nibble mode uses interrupts, no auto requests
// R20: Latch access tagged as DMA or processor
// R21: Request, no DMA, mask set: data interrupt
// R22: Request with DMA select: DMA request instead
// R23: Control interrupt is OR of flags
// R24: Clearing command flag releases ECP handshake
// R25: Host inputs pass two flip-flops first
package port_ctrl_pkg;
    localparam logic [31:0] ADDR_CTRL   = 32'h8000_00A0;
    localparam logic [31:0] ADDR_COND   = 32'h8000_00A4;
    localparam logic [31:0] ADDR_MASK   = 32'h8000_00A8;
    localparam logic [31:0] ADDR_FLAGS  = 32'h8000_00AC;
    localparam logic [31:0] ADDR_DATA   = 32'h8000_00B0;
    localparam logic [31:0] COND_BITS   = 32'h0000_E0FF;
    localparam logic [31:0] FLAG_BITS   = 32'h0000_60FF;
    localparam logic [31:0] BYTE_BITS   = 32'h0000_00FF;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
    localparam int          BIT_REINIT  = 13;
    localparam int          BIT_CMD     = 14;
    localparam int          BIT_DREQ    = 15;
    localparam logic [2:0]  MODE_OFF    = 3'h0;
    localparam logic [2:0]  MODE_COMPAT = 3'h1;
    localparam logic [2:0]  MODE_NIBBLE = 3'h2;
    localparam logic [2:0]  MODE_BYTE   = 3'h3;
    localparam logic [2:0]  MODE_ECPFWD = 3'h4;
    localparam logic [2:0]  MODE_ECPREV = 3'h5;
    localparam logic [1:0]  BC_LAST     = 2'h3;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [1:0]  RD_IDLE     = 2'h0;
    localparam logic [1:0]  RD_FETCH    = 2'h1;
    localparam logic [1:0]  RD_RESP     = 2'h2;

    typedef struct packed {
        logic       cmd_polarity;
        logic       dma_channel_select;
        logic       dma_select_bit;
        logic [3:0] acknowledge_pulse_length;
        logic       busy_override_bit;
        logic       soft_busy_bit;
        logic       full_word_enable;
        logic [2:0] port_protocol_select;
    } ctrl_t;

    localparam logic [12:0] CTRL_RESET = 13'h03F0;

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_REQ  = 4'b0010,
        HS_CMD  = 4'b0100,
        HS_ACK  = 4'b1000
    } hs_state_t;
endpackage

// File: port_host_model.sv
`timescale 1ns/10ps
module port_host_model (
    input  wire logic i_clk,
    output logic [3:0] o_lines
);
    // Bits: 0 forward strobe, 1 reverse strobe, 2 select, 3 init
    // Lines idle low, the true level of the idle host pins
    initial o_lines = 4'h0;

    // Each level is held six cycles so that both edges clear the syncs
    task automatic pulse(input int idx);
        @(posedge i_clk);
        o_lines[idx] <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_lines[idx] <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

// File: tb_port_irq_data_ctrl.sv
`timescale 1ns/10ps
module tb_port_irq_data_ctrl import port_ctrl_pkg::*; ;
    localparam logic [31:0] LATCH_VAL = 32'hC3C3_5A5A;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [31:0] awa = '0, wd = '0, ara = '0, rd;
    logic [1:0]  resp;
    logic        awr, wr_rdy, bv, arr, rv, wstb, oe, cirq, dirq;
    logic [1:0]  bresp, rresp, dreq;
    logic [31:0] rdata, lwd;
    logic [3:0]  host;
    logic        busy, owns, ldma, lfw, ack;
    logic        dma = 1'b0;
    int          err_count = 0, n_checks = 0, cyc = 0, wr_cnt = 0, oe_cnt = 0;
    int          ack_cnt = 0;

    always #20 i_clk = ~i_clk;

    port_host_model i_host (.i_clk(i_clk), .o_lines(host));

    port_irq_data_ctrl i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_awvalid(awv), .i_awaddr(awa), .o_awready(awr),
        .i_wvalid(wv), .i_wdata(wd), .i_wstrb(4'hF), .o_wready(wr_rdy),
        .o_bvalid(bv), .o_bresp(bresp), .i_bready(bry),
        .i_arvalid(arv), .i_araddr(ara), .o_arready(arr),
        .o_rvalid(rv), .o_rdata(rdata), .o_rresp(rresp), .i_rready(rry),
        .i_dma_access(dma), .i_forward_strobe_in(host[0]),
        .i_reverse_strobe_in(host[1]), .i_active_select_in(host[2]),
        .i_host_init_in(host[3]), .i_latch_rdata(LATCH_VAL),
        .o_latch_write_strobe(wstb), .o_latch_output_enable(oe),
        .o_latch_wdata(lwd), .o_latch_full_word(lfw),
        .o_latch_dma_access(ldma), .o_port_control_irq(cirq),
        .o_port_data_irq(dirq), .o_dma_req(dreq), .o_port_busy_out(busy),
        .o_port_ack_out(ack), .o_port_owns_pins(owns)
    );

    // Strobes stand one cycle; counted mid-cycle, where they are settled
    always @(negedge i_clk) begin
        if (wstb === 1'b1) wr_cnt++;
        if (oe === 1'b1) oe_cnt++;
        if (ack === 1'b1) ack_cnt++;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Ceiling sits well above the few hundred cycles the tests need
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
        do begin
            @(posedge i_clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_rdy === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        resp = bresp;
        bry <= 1'b0;
    endtask

    task automatic rdr(input logic [31:0] a);
        @(posedge i_clk);
        arv <= 1'b1; ara <= a; rry <= 1'b1;
        do begin
            @(posedge i_clk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rd = rdata;
        resp = rresp;
        rry <= 1'b0;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        rdr(a);
        chk(rd, exp);
    endtask

    initial begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rchk(ADDR_CTRL, 32'h0000_03F0);
        rchk(ADDR_COND, ZERO_WORD);
        rchk(ADDR_MASK, ZERO_WORD);
        chk({31'h0, busy}, ZERO_WORD);
        chk({31'h0, owns}, ZERO_WORD);
        $display("reset values done");
        // Port still off: the latch decode must work all the same
        wr(ADDR_DATA, LATCH_VAL);
        chk(wr_cnt, 32'h0000_0001);
        chk(lwd & BYTE_BITS, LATCH_VAL & BYTE_BITS);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        chk({31'h0, lfw}, ZERO_WORD);
        rdr(ADDR_DATA);
        chk(rd & BYTE_BITS, LATCH_VAL & BYTE_BITS);
        chk(oe_cnt, 32'h0000_0001);
        chk({31'h0, ldma}, ZERO_WORD);
        rdr(32'h8000_00C0);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("latch decode done");
        wr(ADDR_CTRL, {29'h0, MODE_COMPAT});
        wr(ADDR_MASK, 32'h0000_80FF);
        chk({31'h0, owns}, 32'h0000_0001);
        for (int i = 0; i < 4; i++) i_host.pulse(i);
        rchk(ADDR_COND, 32'h0000_80FF);
        rchk(ADDR_FLAGS, 32'h0000_00FF);
        chk({31'h0, cirq}, 32'h0000_0001);
        chk({31'h0, dirq}, 32'h0000_0001);
        wr(ADDR_FLAGS, 32'h0000_0001);
        rchk(ADDR_COND, 32'h0000_80FE);
        wr(ADDR_COND, 32'h0000_00FE);
        rchk(ADDR_COND, 32'h0000_8000);
        chk({31'h0, cirq}, ZERO_WORD);
        rdr(ADDR_DATA);
        rchk(ADDR_COND, ZERO_WORD);
        chk(ack_cnt, 32'h0000_0001);
        chk({31'h0, dirq}, ZERO_WORD);
        $display("conditions done");
        wr(ADDR_CTRL, 32'h0000_0401);
        i_host.pulse(0);
        chk({30'h0, dreq}, 32'h0000_0001);
        chk({31'h0, dirq}, ZERO_WORD);
        dma <= 1'b1;
        wr(ADDR_DATA, 32'h0000_0011);
        @(posedge i_clk);
        chk({30'h0, dreq}, ZERO_WORD);
        chk({31'h0, ldma}, 32'h0000_0001);
        dma <= 1'b0;
        $display("dma request done");
        wr(ADDR_CTRL, {29'h0, MODE_ECPFWD});
        i_host.pulse(0);
        rdr(ADDR_COND);
        chk(rd & 32'h0000_C000, 32'h0000_4000);
        wr(ADDR_FLAGS, 32'h0000_4000);
        rdr(ADDR_COND);
        chk(rd & 32'h0000_4000, ZERO_WORD);
        chk(ack_cnt, 32'h0000_0003);
        $display("command done");
        wr(ADDR_CTRL, {29'h0, MODE_BYTE});
        wr(ADDR_MASK, 32'h0000_2000);
        i_host.pulse(3);
        rdr(ADDR_COND);
        chk(rd & 32'h0000_2000, 32'h0000_2000);
        chk({31'h0, cirq}, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0009);
        rdr(ADDR_COND);
        chk(rd & 32'h0000_2000, ZERO_WORD);
        chk({31'h0, lfw}, 32'h0000_0001);
        $display("reinit done");
        stop_test();
    end
endmodule
